// ---- src/branch_compare_sequencer.sv ----
// Control-flow execution unit: jumps, calls, returns, compares, skips and branches.
// Contract
// [RULE1] Compare-skip-equal skips two or three words when registers match, 1/2/3 cycles.
// [RULE2] Pointer jump loads PC from the pointer in 2 cycles, flags untouched.
// [RULE3] Pointer call pushes return address, loads PC from pointer, 3 cycles.
// [RULE4] Compare immediate sets Z, N, V, C, H from register minus constant, 1 cycle.
// [RULE5] Skip on register bit clear skips two or three words, 1/2/3 cycles.
// [RULE6] Skip on register bit set skips two or three words when bit is one.
// [RULE7] Skip on I/O bit clear skips the next instruction, 1/2/3 cycles.
// [RULE8] Skip on I/O bit set skips two or three words when bit is one.
// [RULE9] Branch on selected flag set adds offset plus one, 1/2 cycles, flags kept.
// [RULE10] Branch on selected flag clear adds offset plus one when flag is zero.
// [RULE11] Branch equal is taken only when the zero flag is one.
// [RULE12] Branch lower and branch carry set are taken only when carry is one.
// [RULE13] Branch same-or-higher and carry clear are taken only when carry is zero.
// [RULE14] Branch minus is taken only when negative is one, flags kept.
// [RULE15] Signed greater-or-equal branch is taken when N xor V is zero.
// [RULE16] Signed less-than branch is taken when N xor V is one.
// [RULE17] Half-carry branches are taken on H one or H zero, 1/2 cycles.
// [RULE18] Overflow branches are taken on V one or V zero, flags kept.
// [RULE19] Transfer-bit branches are taken on T one or T zero, 1/2 cycles.
// [RULE20] Interrupt-state branches are taken on I one or I zero.
// [RULE21] Relative jump adds offset plus one in 2 cycles; relative call also pushes, 3.
// [RULE22] Both returns pop PC in 4 cycles; only interrupt return sets I.
// [RULE23] Branch takes 1 cycle untaken, 2 taken; skips take 1, 2 or 3.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module branch_compare_sequencer (
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cmdValid,
   input wire branch_compare_pkg::cmd_t cmd,
   output logic cmdReady,
   output logic done,
   output logic [15:0] pc,
   output logic [7:0] flags,
   output logic pushValid,
   output logic [15:0] pushData,
   output logic popReq,
   input wire logic [15:0] popData,
   input wire branch_compare_pkg::apb_req_t apbIn,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   typedef enum logic {IDLE, BUSY} state_t;

   state_t state_reg;
   logic run_reg;
   logic [15:0] pc_reg;
   logic [7:0] flags_reg;
   logic [15:0] pcPend_reg;
   logic [2:0] left_reg;
   logic [2:0] lastCyc_reg;
   logic setI_reg;
   logic done_reg;
   logic pushValid_reg;
   logic [15:0] pushData_reg;
   logic popReq_reg;
   logic popWait_reg;
   logic [31:0] prdata_reg;
   logic accept;
   logic apbWrite;
   logic mapped;
   logic [15:0] pcInc;
   logic [15:0] relPc;
   logic [15:0] skipPc;
   logic [15:0] pcNext;
   logic [7:0] flagsNext;
   logic [2:0] cycNext;
   logic pushNext;
   logic popNext;
   logic isBranch;
   logic isSkip;

   function automatic logic branchCond(branch_compare_pkg::op_t op, logic [2:0] sel, logic [7:0] f);
      logic r;
      r = 1'b0;
      unique case (op)
         branch_compare_pkg::OP_BRANCH_FLAG_SET: r = f[sel]; // [RULE9]
         branch_compare_pkg::OP_BRANCH_FLAG_CLEAR: r = !f[sel]; // [RULE10]
         branch_compare_pkg::OP_BRANCH_EQUAL: r = f[branch_compare_pkg::FLAG_Z]; // [RULE11]
         branch_compare_pkg::OP_BRANCH_NOT_EQUAL: r = !f[branch_compare_pkg::FLAG_Z];
         branch_compare_pkg::OP_BRANCH_CARRY_SET,
         branch_compare_pkg::OP_BRANCH_LOWER: r = f[branch_compare_pkg::FLAG_C]; // [RULE12]
         branch_compare_pkg::OP_BRANCH_CARRY_CLEAR,
         branch_compare_pkg::OP_BRANCH_SAME_HIGHER: r = !f[branch_compare_pkg::FLAG_C]; // [RULE13]
         branch_compare_pkg::OP_BRANCH_MINUS: r = f[branch_compare_pkg::FLAG_N]; // [RULE14]
         branch_compare_pkg::OP_BRANCH_PLUS: r = !f[branch_compare_pkg::FLAG_N];
         branch_compare_pkg::OP_BRANCH_SIGNED_GE:
            r = !(f[branch_compare_pkg::FLAG_N] ^ f[branch_compare_pkg::FLAG_V]); // [RULE15]
         branch_compare_pkg::OP_BRANCH_SIGNED_LT:
            r = f[branch_compare_pkg::FLAG_N] ^ f[branch_compare_pkg::FLAG_V]; // [RULE16]
         branch_compare_pkg::OP_BRANCH_HALFCARRY_SET: r = f[branch_compare_pkg::FLAG_H]; // [RULE17]
         branch_compare_pkg::OP_BRANCH_HALFCARRY_CLEAR: r = !f[branch_compare_pkg::FLAG_H]; // [RULE17]
         branch_compare_pkg::OP_BRANCH_TRANSFER_SET: r = f[branch_compare_pkg::FLAG_T]; // [RULE19]
         branch_compare_pkg::OP_BRANCH_TRANSFER_CLEAR: r = !f[branch_compare_pkg::FLAG_T]; // [RULE19]
         branch_compare_pkg::OP_BRANCH_OVERFLOW_SET: r = f[branch_compare_pkg::FLAG_V]; // [RULE18]
         branch_compare_pkg::OP_BRANCH_OVERFLOW_CLEAR: r = !f[branch_compare_pkg::FLAG_V]; // [RULE18]
         branch_compare_pkg::OP_BRANCH_IRQ_ENABLED: r = f[branch_compare_pkg::FLAG_I]; // [RULE20]
         branch_compare_pkg::OP_BRANCH_IRQ_DISABLED: r = !f[branch_compare_pkg::FLAG_I]; // [RULE20]
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic skipCond(branch_compare_pkg::cmd_t c);
      logic r;
      r = 1'b0;
      unique case (c.op)
         branch_compare_pkg::OP_COMPARE_SKIP_EQUAL: r = (c.regA == c.regB); // [RULE1]
         branch_compare_pkg::OP_SKIP_REG_BIT_CLEAR: r = !c.regA[c.bitSel]; // [RULE5]
         branch_compare_pkg::OP_SKIP_REG_BIT_SET: r = c.regA[c.bitSel]; // [RULE6]
         branch_compare_pkg::OP_SKIP_IO_BIT_CLEAR: r = !c.ioData[c.bitSel]; // [RULE7]
         branch_compare_pkg::OP_SKIP_IO_BIT_SET: r = c.ioData[c.bitSel]; // [RULE8]
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Subtracts without storing and returns the updated flag byte.
   function automatic logic [7:0] cmpFlags(logic [7:0] a, logic [7:0] b, logic cin, logic keepZ,
                                           logic [7:0] f);
      logic [7:0] r;
      logic [7:0] o;
      r = 8'(a - b - {7'h00, cin});
      o = f;
      o[branch_compare_pkg::FLAG_Z] = (r == 8'h00) && (!keepZ || f[branch_compare_pkg::FLAG_Z]);
      o[branch_compare_pkg::FLAG_N] = r[7];
      o[branch_compare_pkg::FLAG_V] = (a[7] & !b[7] & !r[7]) | (!a[7] & b[7] & r[7]);
      o[branch_compare_pkg::FLAG_C] = (!a[7] & b[7]) | (b[7] & r[7]) | (r[7] & !a[7]);
      o[branch_compare_pkg::FLAG_H] = (!a[3] & b[3]) | (b[3] & r[3]) | (r[3] & !a[3]);
      return o;
   endfunction

   assign cmdReady = (state_reg == IDLE) && run_reg;
   assign accept = cmdValid && cmdReady && ce;
   assign pcInc = pc_reg + 16'h0001;
   assign relPc = pc_reg + {{4{cmd.offset[11]}}, cmd.offset} + 16'h0001;
   assign skipPc = pc_reg + (cmd.nextTwoWord ? 16'h0003 : 16'h0002);

   always_comb begin
      pcNext = pcInc;
      cycNext = branch_compare_pkg::CYC_ONE;
      flagsNext = flags_reg;
      pushNext = 1'b0;
      popNext = 1'b0;
      isBranch = 1'b0;
      isSkip = 1'b0;
      unique case (cmd.op)
         branch_compare_pkg::OP_RELATIVE_JUMP: begin
            pcNext = relPc; // [RULE21]
            cycNext = branch_compare_pkg::CYC_JUMP;
         end
         branch_compare_pkg::OP_POINTER_JUMP: begin
            pcNext = cmd.pointer; // [RULE2]
            cycNext = branch_compare_pkg::CYC_JUMP;
         end
         branch_compare_pkg::OP_RELATIVE_CALL: begin
            pcNext = relPc; // [RULE21]
            cycNext = branch_compare_pkg::CYC_CALL;
            pushNext = 1'b1;
         end
         branch_compare_pkg::OP_POINTER_CALL: begin
            pcNext = cmd.pointer; // [RULE3]
            cycNext = branch_compare_pkg::CYC_CALL;
            pushNext = 1'b1;
         end
         branch_compare_pkg::OP_SUBROUTINE_RETURN,
         branch_compare_pkg::OP_INTERRUPT_RETURN: begin
            cycNext = branch_compare_pkg::CYC_RET; // [RULE22]
            popNext = 1'b1;
         end
         branch_compare_pkg::OP_COMPARE_REGISTERS,
         branch_compare_pkg::OP_COMPARE_IMMEDIATE: begin
            flagsNext = cmpFlags(cmd.regA, cmd.regB, 1'b0, 1'b0, flags_reg); // [RULE4]
         end
         branch_compare_pkg::OP_COMPARE_REGISTERS_CARRY: begin
            flagsNext = cmpFlags(cmd.regA, cmd.regB, flags_reg[branch_compare_pkg::FLAG_C], 1'b1, flags_reg);
         end
         branch_compare_pkg::OP_COMPARE_SKIP_EQUAL,
         branch_compare_pkg::OP_SKIP_REG_BIT_CLEAR, branch_compare_pkg::OP_SKIP_REG_BIT_SET,
         branch_compare_pkg::OP_SKIP_IO_BIT_CLEAR, branch_compare_pkg::OP_SKIP_IO_BIT_SET: begin
            isSkip = 1'b1;
            if (skipCond(cmd)) begin
               pcNext = skipPc; // [RULE1] [RULE5] [RULE6] [RULE7] [RULE8]
               cycNext = cmd.nextTwoWord ? branch_compare_pkg::CYC_SKIP2
                                         : branch_compare_pkg::CYC_SKIP1; // [RULE23]
            end
         end
         default: begin
            isBranch = 1'b1;
            if (branchCond(cmd.op, cmd.flagSel, flags_reg)) begin
               pcNext = relPc; // [RULE9] [RULE10]
               cycNext = branch_compare_pkg::CYC_TAKEN; // [RULE23]
            end
         end
      endcase
   end

   assign apbWrite = apbIn.psel && apbIn.penable && apbIn.pwrite && mapped;
   assign mapped = (apbIn.paddr == branch_compare_pkg::OFS_CTRL) || (apbIn.paddr == branch_compare_pkg::OFS_PC)
                   || (apbIn.paddr == branch_compare_pkg::OFS_FLAGS)
                   || (apbIn.paddr == branch_compare_pkg::OFS_STATUS);
   assign pready = 1'b1;
   assign pslverr = apbIn.psel && apbIn.penable && !mapped;

   // Sequencing: single-cycle work finishes at the accepting edge, the rest counts down.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_reg <= IDLE;
         left_reg <= 3'h0;
         pcPend_reg <= branch_compare_pkg::PC_RESET;
         lastCyc_reg <= 3'h0;
         setI_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (ce) begin
         done_reg <= 1'b0;
         unique case (state_reg)
            IDLE: begin
               if (accept) begin
                  lastCyc_reg <= cycNext;
                  setI_reg <= (cmd.op == branch_compare_pkg::OP_INTERRUPT_RETURN); // [RULE22]
                  pcPend_reg <= pcNext;
                  if (cycNext == branch_compare_pkg::CYC_ONE) begin
                     done_reg <= 1'b1;
                  end else begin
                     state_reg <= BUSY;
                     left_reg <= 3'(cycNext - 3'h1);
                  end
               end
            end
            BUSY: begin
               if (popWait_reg) begin
                  pcPend_reg <= popData; // [RULE22]
               end
               left_reg <= 3'(left_reg - 3'h1);
               if (left_reg == 3'h1) begin
                  state_reg <= IDLE;
                  done_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   // Program counter and flags; a bus write in the same cycle overrides execution.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pc_reg <= branch_compare_pkg::PC_RESET;
         flags_reg <= branch_compare_pkg::FLAGS_RESET;
      end else if (ce) begin
         if (accept) begin
            flags_reg <= flagsNext;
            if (cycNext == branch_compare_pkg::CYC_ONE) begin
               pc_reg <= pcNext;
            end
         end
         if (state_reg == BUSY && left_reg == 3'h1) begin
            pc_reg <= pcPend_reg;
            if (setI_reg) begin
               flags_reg[branch_compare_pkg::FLAG_I] <= 1'b1; // [RULE22]
            end
         end
         if (apbWrite && apbIn.paddr == branch_compare_pkg::OFS_PC) begin
            pc_reg <= apbIn.pwdata[15:0];
         end
         if (apbWrite && apbIn.paddr == branch_compare_pkg::OFS_FLAGS) begin
            flags_reg <= apbIn.pwdata[7:0];
         end
      end
   end

   // Stack requests: push the return address, or ask for the popped one.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pushValid_reg <= 1'b0;
         pushData_reg <= 16'h0000;
         popReq_reg <= 1'b0;
         popWait_reg <= 1'b0;
      end else if (ce) begin
         pushValid_reg <= accept && pushNext; // [RULE3] [RULE21]
         popReq_reg <= accept && popNext;
         popWait_reg <= popReq_reg;
         if (accept) begin
            pushData_reg <= pcInc;
         end
      end
   end

   // Register bus: control, read data captured in the setup phase.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         run_reg <= branch_compare_pkg::CTRL_RUN_RESET;
         prdata_reg <= 32'h00000000;
      end else if (ce) begin
         if (apbWrite && apbIn.paddr == branch_compare_pkg::OFS_CTRL) begin
            run_reg <= apbIn.pwdata[branch_compare_pkg::CTRL_RUN];
         end
         if (apbIn.psel && !apbIn.penable) begin
            prdata_reg <= 32'h00000000;
            unique case (apbIn.paddr)
               branch_compare_pkg::OFS_CTRL: prdata_reg[branch_compare_pkg::CTRL_RUN] <= run_reg;
               branch_compare_pkg::OFS_PC: prdata_reg[15:0] <= pc_reg;
               branch_compare_pkg::OFS_FLAGS: prdata_reg[7:0] <= flags_reg;
               branch_compare_pkg::OFS_STATUS: begin
                  prdata_reg[branch_compare_pkg::STATUS_BUSY] <= (state_reg == BUSY);
                  prdata_reg[branch_compare_pkg::STATUS_CYC_LSB +: 3] <= lastCyc_reg;
               end
               default: prdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   assign done = done_reg;
   assign pc = pc_reg;
   assign flags = flags_reg;
   assign pushValid = pushValid_reg;
   assign pushData = pushData_reg;
   assign popReq = popReq_reg;
   assign prdata = prdata_reg;

   // Cycles seen since the last accepted instruction, for the checks below.
   logic [2:0] elapsed_reg;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         elapsed_reg <= 3'h0;
      end else if (ce) begin
         if (accept) begin
            elapsed_reg <= 3'h1;
         end else if (state_reg == BUSY) begin
            elapsed_reg <= 3'(elapsed_reg + 3'h1);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence sAccept(branch_compare_pkg::op_t o);
      accept && cmd.op == o;
   endsequence

   a_cycle_count: assert property (done_reg |-> elapsed_reg == lastCyc_reg) // [RULE23]
      else $error("Instruction length differs from its cycle count.");
   a_pointer_jump: assert property (sAccept(branch_compare_pkg::OP_POINTER_JUMP) // [RULE2]
      |-> cycNext == branch_compare_pkg::CYC_JUMP && pcNext == cmd.pointer && flagsNext == flags_reg)
      else $error("Pointer jump target or length wrong.");
   a_pointer_call: assert property (sAccept(branch_compare_pkg::OP_POINTER_CALL) // [RULE3]
      |-> ce ##1 pushValid_reg && pushData_reg == $past(pcInc) && state_reg == BUSY)
      else $error("Pointer call did not push the return address.");
   a_return_pop: assert property (sAccept(branch_compare_pkg::OP_SUBROUTINE_RETURN) // [RULE22]
      |-> cycNext == branch_compare_pkg::CYC_RET ##1 popReq_reg)
      else $error("Return did not request a pop.");
   a_compare_zero: assert property (sAccept(branch_compare_pkg::OP_COMPARE_IMMEDIATE) // [RULE4]
      |-> flagsNext[branch_compare_pkg::FLAG_Z] == (cmd.regA == cmd.regB) && cycNext == branch_compare_pkg::CYC_ONE)
      else $error("Compare immediate zero flag wrong.");
   a_branch_taken: assert property (accept && isBranch && cycNext != branch_compare_pkg::CYC_ONE // [RULE9]
      |-> pcNext == relPc && cycNext == branch_compare_pkg::CYC_TAKEN && flagsNext == flags_reg)
      else $error("Taken branch target wrong.");
   a_branch_untaken: assert property (accept && isBranch && pcNext != relPc // [RULE23]
      |-> pcNext == pcInc && cycNext == branch_compare_pkg::CYC_ONE ##1 done_reg || !ce)
      else $error("Untaken branch not single cycle.");
   a_skip_length: assert property (accept && isSkip && pcNext == skipPc // [RULE1]
      |-> cycNext == (cmd.nextTwoWord ? branch_compare_pkg::CYC_SKIP2 : branch_compare_pkg::CYC_SKIP1))
      else $error("Skip length wrong.");

endmodule // branch_compare_sequencer

`default_nettype wire

// ---- src/branch_compare_pkg.sv ----
// Package with constants, commands and carriers for the branch and compare sequencer.
package branch_compare_pkg;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PC = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;

   localparam int CTRL_RUN = 0;
   localparam int STATUS_BUSY = 0;
   localparam int STATUS_CYC_LSB = 4;

   localparam logic CTRL_RUN_RESET = 1'b1;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TAKEN = 3'h2;
   localparam logic [2:0] CYC_JUMP = 3'h2;
   localparam logic [2:0] CYC_CALL = 3'h3;
   localparam logic [2:0] CYC_RET = 3'h4;
   localparam logic [2:0] CYC_SKIP1 = 3'h2;
   localparam logic [2:0] CYC_SKIP2 = 3'h3;

   typedef enum logic [5:0] {
      OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_POINTER_CALL,
      OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL,
      OP_COMPARE_REGISTERS, OP_COMPARE_REGISTERS_CARRY, OP_COMPARE_IMMEDIATE,
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
      OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
      OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
      OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TRANSFER_SET,
      OP_BRANCH_TRANSFER_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
      OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED
   } op_t;

   typedef struct packed {
      op_t op;
      logic [2:0] flagSel;
      logic [11:0] offset;
      logic [7:0] regA;
      logic [7:0] regB;
      logic [2:0] bitSel;
      logic [7:0] ioData;
      logic nextTwoWord;
      logic [15:0] pointer;
   } cmd_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

// ---- sim/branch_compare_sequencer_tb_top.sv ----
// Self-checking testbench for the branch and compare sequencer.
`timescale 1ns/100ps
`default_nettype none

module branch_compare_sequencer_tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic cmdValid = 1'b0;
   branch_compare_pkg::cmd_t cmd = '0;
   branch_compare_pkg::cmd_t c = '0;
   branch_compare_pkg::apb_req_t apbReq = '0;
   logic [15:0] popData = 16'h0000;
   logic cmdReady, done, pushValid, popReq, pready, pslverr, err, t, sk, popSeen;
   logic [15:0] pc, pushData, pushed, expPc;
   logic [7:0] flags, fs;
   logic [8:0] ext;
   logic [31:0] prdata, rd;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int nCyc, sel, n;
   int stall = 0;
   logic [7:0] flagSet [4] = '{8'h00, 8'hFF, 8'h0C, 8'h04};
   int bitOf [20] = '{0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5, 5, 6, 6, 3, 3, 7, 7};
   int pol [20] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0};
   logic [7:0] cmpA [4] = '{8'h10, 8'h00, 8'h80, 8'h05};
   logic [7:0] cmpB [4] = '{8'h01, 8'h01, 8'h01, 8'h05};
   logic [7:0] cmpF [4] = '{8'h20, 8'h25, 8'h28, 8'h02};
   int skOp [5] = '{6, 10, 11, 12, 13};

   always #20 clock = ~clock;

   branch_compare_sequencer u_dut (.clock(clock), .nrst(nrst), .ce(ce), .cmdValid(cmdValid), .cmd(cmd),
      .cmdReady(cmdReady), .done(done), .pc(pc), .flags(flags), .pushValid(pushValid), .pushData(pushData),
      .popReq(popReq), .popData(popData), .apbIn(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic report_and_stop();
      $display("Checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         $display("MISMATCH t=%0t timeout", $time);
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic busXfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge clock);
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= wr;
      apbReq.paddr <= addr;
      apbReq.pwdata <= data;
      @(posedge clock);
      apbReq.penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask

   task automatic setOp(input int k);
      c = '0;
      c.op = branch_compare_pkg::op_t'(k);
   endtask

   // Loads PC and flags over the bus, runs c, then checks PC, cycle count and flags.
   task automatic go(input logic [15:0] pc0, input logic [7:0] fl0, input logic [15:0] ePc, input int eCyc,
                     input logic [7:0] eFl);
      busXfer(1'b1, branch_compare_pkg::OFS_PC, {16'h0000, pc0});
      busXfer(1'b1, branch_compare_pkg::OFS_FLAGS, {24'h000000, fl0});
      pushed = 16'h0000;
      popSeen = 1'b0;
      @(posedge clock);
      cmd <= c;
      cmdValid <= 1'b1;
      do @(posedge clock); while (cmdReady !== 1'b1);
      cmdValid <= 1'b0;
      nCyc = 1 + stall;
      // Holds the clock enable low after the accepting edge; every frozen cycle adds one.
      if (stall > 0) begin
         ce <= 1'b0;
         repeat (stall) @(posedge clock);
         ce <= 1'b1;
      end
      @(negedge clock);
      while (done !== 1'b1) begin
         if (pushValid === 1'b1) pushed = pushData;
         if (popReq === 1'b1) popSeen = 1'b1;
         nCyc++;
         @(negedge clock);
      end
      chk(pc, ePc, "pc");
      chk(nCyc, eCyc, "cycles");
      chk(flags, eFl, "flags");
   endtask

   initial begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      busXfer(1'b0, branch_compare_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h1, "ctrl reset");
      busXfer(1'b0, branch_compare_pkg::OFS_PC, 32'h0);
      chk(rd, 32'h0, "pc reset");
      busXfer(1'b1, 8'h10, 32'hFF);
      busXfer(1'b0, 8'h10, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000, "unmapped");
      busXfer(1'b1, branch_compare_pkg::OFS_CTRL, 32'h0);
      @(negedge clock);
      chk(cmdReady, 32'h0, "stopped ready");
      busXfer(1'b1, branch_compare_pkg::OFS_CTRL, 32'h1);
      for (int i = 14; i <= 33; i++) begin
         for (int j = 0; j < 4; j++) begin
            setOp(i);
            fs = flagSet[j];
            c.flagSel = 3'(i + j);
            c.offset = j[0] ? 12'hFFD : 12'h7FF;
            sel = (i < 16) ? int'(c.flagSel) : bitOf[i - 14];
            ext = {fs[2] ^ fs[3], fs};
            t = (ext[sel] == pol[i - 14][0]);
            expPc = t ? 16'h0101 + {{4{c.offset[11]}}, c.offset} : 16'h0101;
            go(16'h0100, fs, expPc, t ? 2 : 1, fs);
         end
      end
      for (int i = 0; i < 5; i++) begin
         for (int j = 0; j < 4; j++) begin
            n = skOp[i];
            setOp(n);
            c.bitSel = j[0] ? 3'h5 : 3'h4;
            c.regA = (n > 11) ? 8'hDF : 8'h20;
            c.ioData = ~c.regA;
            c.regB = j[0] ? 8'h20 : 8'h21;
            c.nextTwoWord = j[1];
            sk = (n == 10 || n == 12) ? !j[0] : j[0];
            expPc = 16'h0201 + (sk ? 16'(j[1] + 1) : 16'h0000);
            go(16'h0200, 8'hA5, expPc, sk ? 2 + j[1] : 1, 8'hA5);
         end
      end
      for (int j = 0; j < 8; j++) begin
         setOp(j[0] ? 9 : 7);
         c.regA = cmpA[j / 2];
         c.regB = cmpB[j / 2];
         go(16'h0300, 8'h00, 16'h0301, 1, cmpF[j / 2]);
      end
      setOp(8);
      c.regA = 8'h05;
      c.regB = 8'h04;
      go(16'h0300, 8'h03, 16'h0301, 1, 8'h02);
      go(16'h0300, 8'h01, 16'h0301, 1, 8'h00);
      setOp(0);
      c.offset = 12'h800;
      go(16'h1000, 8'hFF, 16'h0801, 2, 8'hFF);
      stall = 3;
      go(16'h1000, 8'hFF, 16'h0801, 5, 8'hFF);
      stall = 0;
      c.op = branch_compare_pkg::OP_RELATIVE_CALL;
      go(16'h1000, 8'h00, 16'h0801, 3, 8'h00);
      chk(pushed, 16'h1001, "push");
      setOp(1);
      c.pointer = 16'hBEEF;
      go(16'h1000, 8'h5A, 16'hBEEF, 2, 8'h5A);
      c.op = branch_compare_pkg::OP_POINTER_CALL;
      go(16'h1000, 8'h00, 16'hBEEF, 3, 8'h00);
      chk(pushed, 16'h1001, "push");
      @(posedge clock) popData <= 16'h0456;
      setOp(4);
      go(16'h2000, 8'h00, 16'h0456, 4, 8'h00);
      chk(popSeen, 32'h1, "pop");
      setOp(5);
      @(posedge clock) popData <= 16'hFBA9;
      go(16'h2000, 8'h01, 16'hFBA9, 4, 8'h81);
      chk(popSeen, 32'h1, "pop");
      busXfer(1'b0, branch_compare_pkg::OFS_STATUS, 32'h0);
      chk(rd[6:4], 32'h4, "status cycles");
      report_and_stop();
   end
endmodule // branch_compare_sequencer_tb_top

`default_nettype wire
